//--- src/fsp_pkg.sv
// fsp_pkg: constants and state type for the frame status and port register bank.
// assumes a 16-bit register port with a 4-bit word address on a single core clock.
package fsp_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 9;
    localparam int unsigned PORT_W = 16;
    localparam int unsigned EV_W = 2;

    // register word addresses
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_A_DIR = 4'h4;
    localparam logic [3:0] OFS_A_DATA = 4'h5;
    localparam logic [3:0] OFS_B_DIR = 4'h6;
    localparam logic [3:0] OFS_B_DATA = 4'h7;
    localparam logic [3:0] OFS_CTRL = 4'h8;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h9;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hA;

    // frame count range
    localparam logic [8:0] CNT_FIRST = 9'h000;
    localparam logic [8:0] CNT_LAST = 9'h173;

    // status field positions
    localparam int unsigned ST_CNT_LSB = 7;
    localparam int unsigned ST_ROLE_BIT = 4;
    localparam int unsigned ST_SYNC_BIT = 3;
    localparam int unsigned ST_FRAME_BIT = 2;

    // control field positions
    localparam int unsigned CTL_SYNC_CLR = 0;
    localparam int unsigned CTL_FRAME_CLR = 1;
    localparam int unsigned CTL_PAT_SEL = 2;
    localparam int unsigned CTL_W = 3;

    // event bit positions in interrupt status and mask
    localparam int unsigned IRQ_SYNC = 0;
    localparam int unsigned IRQ_FRAME = 1;

    // reset values
    localparam logic [2:0] CTRL_RST = 3'h3;
    localparam logic [15:0] DIR_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [1:0] MASK_RST = 2'h0;

    // encodings
    localparam logic PAT_PRIMARY = 1'b0;
    localparam logic PAT_ALT = 1'b1;
    localparam logic ROLE_BASE = 1'b0;
    localparam logic ROLE_HANDSET = 1'b1;

    typedef struct packed {
        logic role_s1;
        logic role_s2;
        logic [PORT_W-1:0] pa_s1;
        logic [PORT_W-1:0] pa_s2;
        logic [PORT_W-1:0] pb_s1;
        logic [PORT_W-1:0] pb_s2;
        logic [CNT_W-1:0] cnt_shadow;
        logic sync_flag;
        logic frame_flag;
        logic [CTL_W-1:0] ctrl;
        logic [EV_W-1:0] irq_stat;
        logic [EV_W-1:0] irq_mask;
        logic [PORT_W-1:0] a_dir;
        logic [PORT_W-1:0] a_out;
        logic [PORT_W-1:0] b_dir;
        logic [PORT_W-1:0] b_out;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } fsp_state_s;

    localparam fsp_state_s STATE_RST = '{
        role_s1: 1'b0,
        role_s2: 1'b0,
        pa_s1: DATA_RST,
        pa_s2: DATA_RST,
        pb_s1: DATA_RST,
        pb_s2: DATA_RST,
        cnt_shadow: CNT_FIRST,
        sync_flag: 1'b0,
        frame_flag: 1'b0,
        ctrl: CTRL_RST,
        irq_stat: 2'h0,
        irq_mask: MASK_RST,
        a_dir: DIR_RST,
        a_out: DATA_RST,
        b_dir: DIR_RST,
        b_out: DATA_RST,
        rdata: 16'h0000,
        irq: 1'b0
    };

endpackage : fsp_pkg

//--- src/fsp_regs.sv
// fsp_regs: frame timing status register, two 16-bit pin ports, flag control,
// interrupt status and mask, all on one register port.
// assumes frame counters, sync detector and frame start come from logic on clk;
// the role pin and the port pins are asynchronous and synchronised here.
//
// Summary of operation
// - status bits 15..7 report frame position 0 to 371, never higher.
// - reported count comes from a buffered copy, read returns a consistent value.
// - handset role reports the single shared frame counter.
// - base role reports the transmit frame counter.
// - status bit 4 mirrors role pin: 0 base, 1 handset.
// - status bit 3 set when the selected sync pattern is detected.
// - status bit 2 set at new frame start, zero once cleared.
// - each flag clears on its control bit written 1 to 0; rewrite 1 first.
// - pattern select 0 picks primary word, 1 picks alternate pattern.
// - port A direction bits: 0 input, 1 output, independent, read back.
// - port B direction bits: 0 input, 1 output, independent, read back.
// - writing a port data register loads values driven on output pins.
// - reading a port data register returns actual pin levels.
`timescale 1ns/1ps
module fsp_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    input wire logic station_role_pin,
    input wire logic [8:0] hs_frame_cnt,
    input wire logic [8:0] tx_frame_cnt,
    input wire logic frame_start,
    input wire logic primary_sync_hit,
    input wire logic alt_sync_hit,
    output logic sync_pattern_sel,
    input wire logic [15:0] port_a_i,
    output logic [15:0] port_a_o,
    output logic [15:0] port_a_oe,
    input wire logic [15:0] port_b_i,
    output logic [15:0] port_b_o,
    output logic [15:0] port_b_oe
);

    fsp_pkg::fsp_state_s r;
    fsp_pkg::fsp_state_s n;

    logic [8:0] sel_cnt;
    logic sync_hit;
    logic wr_ctrl;
    logic sync_clr;
    logic frame_clr;
    logic [1:0] events;
    logic [1:0] rd_clr;
    logic [15:0] status_word;

    always_comb begin
        n = r;

        // synchronisers; first stage read only by the second
        n.role_s1 = station_role_pin;
        n.role_s2 = r.role_s1;
        n.pa_s1 = port_a_i;
        n.pa_s2 = r.pa_s1;
        n.pb_s1 = port_b_i;
        n.pb_s2 = r.pb_s1;

        // handset uses the shared counter, base the transmit counter
        if (r.role_s2 == fsp_pkg::ROLE_HANDSET) begin
            sel_cnt = hs_frame_cnt;
        end else begin
            sel_cnt = tx_frame_cnt;
        end

        // shadow copy only follows legal counts
        if (sel_cnt <= fsp_pkg::CNT_LAST) begin
            n.cnt_shadow = sel_cnt;
        end

        // detector event for the pattern in use
        if (r.ctrl[fsp_pkg::CTL_PAT_SEL] == fsp_pkg::PAT_ALT) begin
            sync_hit = alt_sync_hit;
        end else begin
            sync_hit = primary_sync_hit;
        end

        // flag clears fire on a 1 to 0 write of the control bit
        wr_ctrl = reg_wr && (reg_addr == fsp_pkg::OFS_CTRL);
        sync_clr = wr_ctrl && r.ctrl[fsp_pkg::CTL_SYNC_CLR]
            && !reg_wdata[fsp_pkg::CTL_SYNC_CLR];
        frame_clr = wr_ctrl && r.ctrl[fsp_pkg::CTL_FRAME_CLR]
            && !reg_wdata[fsp_pkg::CTL_FRAME_CLR];
        if (wr_ctrl) begin
            n.ctrl = reg_wdata[fsp_pkg::CTL_W-1:0];
        end

        // set wins over clear
        n.sync_flag = (r.sync_flag && !sync_clr) || sync_hit;
        n.frame_flag = (r.frame_flag && !frame_clr) || frame_start;

        // sticky events, cleared by a read of the interrupt status
        events = '0;
        events[fsp_pkg::IRQ_SYNC] = sync_hit;
        events[fsp_pkg::IRQ_FRAME] = frame_start;
        rd_clr = '0;
        if (reg_rd && (reg_addr == fsp_pkg::OFS_IRQ_STAT)) begin
            rd_clr = '1;
        end
        n.irq_stat = (r.irq_stat & ~rd_clr) | events;

        // status word: reserved bits zero
        status_word = '0;
        status_word[fsp_pkg::ST_CNT_LSB +: fsp_pkg::CNT_W] = r.cnt_shadow;
        status_word[fsp_pkg::ST_ROLE_BIT] = r.role_s2;
        status_word[fsp_pkg::ST_SYNC_BIT] = r.sync_flag;
        status_word[fsp_pkg::ST_FRAME_BIT] = r.frame_flag;

        // writes; status has no write path
        if (reg_wr) begin
            case (reg_addr)
                fsp_pkg::OFS_A_DIR: begin
                    n.a_dir = reg_wdata;
                end
                fsp_pkg::OFS_A_DATA: begin
                    n.a_out = reg_wdata;
                end
                fsp_pkg::OFS_B_DIR: begin
                    n.b_dir = reg_wdata;
                end
                fsp_pkg::OFS_B_DATA: begin
                    n.b_out = reg_wdata;
                end
                fsp_pkg::OFS_IRQ_MASK: begin
                    n.irq_mask = reg_wdata[fsp_pkg::EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // read data stands one cycle, zero otherwise
        n.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                fsp_pkg::OFS_STATUS: begin
                    n.rdata = status_word;
                end
                fsp_pkg::OFS_A_DIR: begin
                    n.rdata = r.a_dir;
                end
                fsp_pkg::OFS_A_DATA: begin
                    n.rdata = r.pa_s2;
                end
                fsp_pkg::OFS_B_DIR: begin
                    n.rdata = r.b_dir;
                end
                fsp_pkg::OFS_B_DATA: begin
                    n.rdata = r.pb_s2;
                end
                fsp_pkg::OFS_CTRL: begin
                    n.rdata[fsp_pkg::CTL_W-1:0] = r.ctrl;
                end
                fsp_pkg::OFS_IRQ_STAT: begin
                    n.rdata[fsp_pkg::EV_W-1:0] = r.irq_stat;
                end
                fsp_pkg::OFS_IRQ_MASK: begin
                    n.rdata[fsp_pkg::EV_W-1:0] = r.irq_mask;
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end

        n.irq = |(n.irq_stat & n.irq_mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= fsp_pkg::STATE_RST;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign irq = r.irq;
    assign sync_pattern_sel = r.ctrl[fsp_pkg::CTL_PAT_SEL];
    assign port_a_o = r.a_out;
    assign port_a_oe = r.a_dir;
    assign port_b_o = r.b_out;
    assign port_b_oe = r.b_dir;

endmodule : fsp_regs

//--- bench/fsp_regs_properties.sv
// fsp_regs_properties: port-level assertions for fsp_regs.
// assumes it is bound into fsp_regs and sees only its ports.
`timescale 1ns/1ps
module fsp_regs_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic station_role_pin,
    input wire logic frame_start,
    input wire logic sync_pattern_sel,
    input wire logic [15:0] port_a_i,
    input wire logic [15:0] port_a_o,
    input wire logic [15:0] port_a_oe,
    input wire logic [15:0] port_b_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic st_rd = reg_rd && reg_addr == fsp_pkg::OFS_STATUS;
    a_dir_a: assert property (reg_wr && reg_addr == fsp_pkg::OFS_A_DIR
        |=> port_a_oe == $past(reg_wdata)) else $error("port a direction not loaded");
    b_dir_a: assert property (reg_wr && reg_addr == fsp_pkg::OFS_B_DIR
        |=> port_b_oe == $past(reg_wdata)) else $error("port b direction not loaded");
    a_out_a: assert property (reg_wr && reg_addr == fsp_pkg::OFS_A_DATA
        |=> port_a_o == $past(reg_wdata)) else $error("port a output not loaded");
    st_resv_a: assert property (st_rd |=> reg_rdata[6:5] == 2'h0 && reg_rdata[1:0] == 2'h0)
        else $error("reserved status bits set");
    cnt_range_a: assert property (st_rd |=> reg_rdata[15:7] <= fsp_pkg::CNT_LAST)
        else $error("frame count out of range");
    role_bit_a: assert property ($stable(station_role_pin)[*3] ##0 st_rd
        |=> reg_rdata[4] == $past(station_role_pin)) else $error("role bit wrong");
    pat_sel_a: assert property (reg_wr && reg_addr == fsp_pkg::OFS_CTRL
        |=> sync_pattern_sel == $past(reg_wdata[2])) else $error("pattern select wrong");
    frame_flag_a: assert property (frame_start ##1 st_rd |=> reg_rdata[2])
        else $error("frame flag not set");
    pin_read_a: assert property ($stable(port_a_i)[*3] ##0 reg_rd && reg_addr == fsp_pkg::OFS_A_DATA
        |=> reg_rdata == $past(port_a_i)) else $error("pin read wrong");
endmodule : fsp_regs_properties
bind fsp_regs fsp_regs_properties fsp_regs_properties_i (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .station_role_pin, .frame_start, .sync_pattern_sel,
    .port_a_i, .port_a_o, .port_a_oe, .port_b_oe);

//--- bench/fsp_regs_tb.sv
// fsp_regs_tb: register port tests of fsp_regs.
// assumes pins and frame events are driven directly by the bench.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module fsp_regs_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic role = 1'b1;
    logic [8:0] hs_cnt = 9'h173;
    logic [8:0] tx_cnt = 9'h005;
    logic [2:0] ev = 3'h0; // alt, primary, frame
    logic [15:0] pa_i = 16'hA5C3;
    logic [15:0] reg_rdata, pa_o, pa_oe, pb_o, pb_oe;
    logic irq, sel;
    int bad_count = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    fsp_regs fsp_regs_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .station_role_pin(role), .hs_frame_cnt(hs_cnt), .tx_frame_cnt(tx_cnt),
        .frame_start(ev[0]), .primary_sync_hit(ev[1]), .alt_sync_hit(ev[2]),
        .sync_pattern_sel(sel), .port_a_i(pa_i), .port_a_o(pa_o), .port_a_oe(pa_oe),
        .port_b_i(16'h3C5A), .port_b_o(pb_o), .port_b_oe(pb_oe));
    function automatic logic [15:0] sw(logic [8:0] c, logic r, logic s, logic f);
        return {c, 2'b00, r, s, f, 2'b00};
    endfunction : sw
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd
    task automatic pulse(input logic [2:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 3'h0;
    endtask : pulse
    task automatic results;
        $display("%0d checks %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(fsp_pkg::OFS_A_DIR, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(fsp_pkg::OFS_A_DIR, 16'h8001);
        `CHK(pa_oe, 16'h8001)
        wr(fsp_pkg::OFS_B_DIR, 16'h7FFE);
        `CHK(pb_oe, 16'h7FFE)
        rd(fsp_pkg::OFS_B_DIR, 16'h7FFE);
        wr(fsp_pkg::OFS_A_DATA, 16'h1234);
        `CHK(pa_o, 16'h1234)
        wr(fsp_pkg::OFS_B_DATA, 16'hFEDC);
        `CHK(pb_o, 16'hFEDC)
        rd(fsp_pkg::OFS_A_DATA, 16'hA5C3);
        rd(fsp_pkg::OFS_B_DATA, 16'h3C5A);
        @(posedge clk);
        pa_i <= 16'h0F0F;
        rd(fsp_pkg::OFS_A_DATA, 16'hA5C3);
        rd(fsp_pkg::OFS_A_DATA, 16'h0F0F);
        $display("ports test done");
        rd(fsp_pkg::OFS_STATUS, sw(9'h173, 1'b1, 1'b0, 1'b0));
        @(posedge clk);
        role <= 1'b0;
        repeat (4) @(posedge clk);
        rd(fsp_pkg::OFS_STATUS, sw(9'h005, 1'b0, 1'b0, 1'b0));
        @(posedge clk);
        role <= 1'b1;
        hs_cnt <= 9'h174;
        repeat (4) @(posedge clk);
        rd(fsp_pkg::OFS_STATUS, sw(9'h005, 1'b1, 1'b0, 1'b0));
        @(posedge clk);
        hs_cnt <= 9'h000;
        wr(fsp_pkg::OFS_STATUS, 16'hFFFF);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b0, 1'b0));
        $display("status test done");
        pulse(3'h1);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b0, 1'b1));
        wr(fsp_pkg::OFS_CTRL, 16'h0001);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b0, 1'b0));
        pulse(3'h1);
        wr(fsp_pkg::OFS_CTRL, 16'h0001);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b0, 1'b1));
        wr(fsp_pkg::OFS_CTRL, 16'h0003);
        wr(fsp_pkg::OFS_CTRL, 16'h0001);
        pulse(3'h4);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b0, 1'b0));
        pulse(3'h2);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b1, 1'b0));
        wr(fsp_pkg::OFS_CTRL, 16'h0006);
        `CHK(sel, fsp_pkg::PAT_ALT)
        pulse(3'h2);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b0, 1'b0));
        pulse(3'h4);
        rd(fsp_pkg::OFS_STATUS, sw(9'h000, 1'b1, 1'b1, 1'b0));
        $display("flag test done");
        rd(fsp_pkg::OFS_IRQ_STAT, 16'h0003);
        rd(fsp_pkg::OFS_IRQ_STAT, 16'h0000);
        wr(fsp_pkg::OFS_IRQ_MASK, 16'h0002);
        pulse(3'h4);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        pulse(3'h1);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b1)
        rd(fsp_pkg::OFS_IRQ_STAT, 16'h0003);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        $display("irq test done");
        results();
    end
endmodule : fsp_regs_tb
